// *** logic/fspc_map.vh ***
// register map, field positions and timing constants of the flash self-programming controller
//
// Contract
// - rows of 64 instructions, one row per program, erase covers eight rows
// - erase blocks align on 512-word boundaries, rows on 64-word boundaries
// - target address is page pointer as upper byte plus effective pointer
// - low accesses carry bits 15..0, high accesses bits 23..16, word or byte
// - latch stores fill holding latches; array changes only when a sequence runs
// - latches load in any order; the latest write to a latch wins
// - a write runs whatever number of latch stores preceded it
// - each latch store completes in two cycles, touching only the buffers
// - key register write-only; 55h then aah in consecutive writes before start
// - start bit 15 launches self-timed operation, stalls core, clears when done
// - modify-allow bit 14 gates every program and erase
// - read-only fault bit 13 set on bad sequence, clear after normal completion
// - erase-select bit 6 picks erase or program for the next start
// - codes 0011, 0010, 0001, 1111; kind mismatch with bit 6 means no operation
// - bulk erase only in serial programming mode; other codes unimplemented
// - control bits reset only on power-on reset
// - control bits 12..7 and 5..4 read as zero
`ifndef FSPC_MAP_VH
`define FSPC_MAP_VH

`define FSPC_ADDR_CTRL 4'h0
`define FSPC_ADDR_KEY 4'h1
`define FSPC_ADDR_PAGE 4'h2
`define FSPC_ADDR_STAT 4'h3

`define FSPC_BIT_START 15
`define FSPC_BIT_ALLOW 14
`define FSPC_BIT_FAULT 13
`define FSPC_BIT_ERASE 6
`define FSPC_CTRL_WMASK 16'h404f

`define FSPC_KEY_FIRST 8'h55
`define FSPC_KEY_SECOND 8'haa

`define FSPC_OP_WORD 4'h3
`define FSPC_OP_BLOCK 4'h2
`define FSPC_OP_ROW 4'h1
`define FSPC_OP_BULK 4'hf

`define FSPC_PROG_NS 2000
`define FSPC_ERASE_NS 20000
`define FSPC_CLK_NS 10

`endif

// *** logic/fspc_latch.v ***
// holding latch bank for one row of 24-bit instruction words
`timescale 1ns/1ps
`default_nettype none
module fspc_latch #(
  parameter ROW_WORDS = 64,
  parameter IDX_W = 6
) (
  input wire i_clk,
  input wire i_wr,
  input wire [IDX_W-1:0] i_wr_idx,
  input wire i_hi,
  input wire [1:0] i_be,
  input wire [15:0] i_wdata,
  input wire [IDX_W-1:0] i_rd_idx,
  output reg [23:0] o_rdata
);
  // no reset: contents are unknown at power-up, software pads unused words
  reg [23:0] mem [0:ROW_WORDS-1];

  always @(posedge i_clk) begin
    if (i_wr) begin
      // any order, latest write replaces earlier data
      if (i_hi) begin
        if (i_be[0]) mem[i_wr_idx][23:16] <= i_wdata[7:0];
      end else begin
        if (i_be[0]) mem[i_wr_idx][7:0] <= i_wdata[7:0];
        if (i_be[1]) mem[i_wr_idx][15:8] <= i_wdata[15:8];
      end
    end
    o_rdata <= mem[i_rd_idx];
  end
endmodule // fspc_latch
`default_nettype wire

// *** logic/fspc_ctrl.v ***
// flash self-programming controller: control/key registers, latch loads and self-timed sequences
`timescale 1ns/1ps
`default_nettype none
`include "fspc_map.vh"
module fspc_ctrl #(
  parameter ROW_WORDS = 64,
  parameter IDX_W = 6,
  parameter BLOCK_ROWS = 8,
  parameter PROG_CYCLES = (`FSPC_PROG_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS,
  parameter ERASE_CYCLES = (`FSPC_ERASE_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_por,
  input wire i_serial_programming,
  // register bus
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // latch stores issued by the core
  input wire i_latch_store_op,
  input wire i_high_latch_store,
  input wire i_byte_mode,
  input wire [15:0] i_effective_pointer,
  input wire [15:0] i_store_data,
  output wire o_store_done,
  output wire o_core_stall,
  // flash array side
  output reg o_arr_wr,
  output reg o_arr_erase,
  output reg [23:0] o_arr_addr,
  output reg [23:0] o_arr_data,
  output reg [IDX_W+3:0] o_arr_count
);
  localparam ST_IDLE = 2'h0;
  localparam ST_PROG = 2'h1;
  localparam ST_ERASE = 2'h2;
  localparam ST_DONE = 2'h3;
  localparam KEY_NONE = 2'h0;
  localparam KEY_ONE = 2'h1;
  localparam KEY_OK = 2'h2;
  // spans and counts, cut on purpose to the widths that they meet
  localparam integer BLK_WORDS = ROW_WORDS * BLOCK_ROWS;
  localparam [23:0] ROW_SPAN = ROW_WORDS[23:0];
  localparam [23:0] BLK_SPAN = BLK_WORDS[23:0];
  localparam [IDX_W+3:0] ROW_COUNT = ROW_WORDS[IDX_W+3:0];
  localparam [IDX_W+3:0] BLK_COUNT = BLK_WORDS[IDX_W+3:0];


  ////////////////////////////////////////////////////////////////////////////////
  // word-address arithmetic, shared by row and block alignment
  function [23:0] fspc_align;
    input [23:0] addr;
    input [23:0] words;
    begin
      // program memory counts two address units per instruction word
      fspc_align = addr - (addr % (words * 24'h000002));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  reg start_ff, nxt_start;
  reg allow_ff, nxt_allow;
  reg fault_ff, nxt_fault;
  reg erase_ff, nxt_erase;
  reg [3:0] opsel_ff, nxt_opsel;
  reg [7:0] page_ff, nxt_page;
  reg [1:0] key_ff, nxt_key;
  reg [1:0] state_ff, nxt_state;
  reg [31:0] timer_ff, nxt_timer;
  reg [IDX_W+3:0] cnt_ff, nxt_cnt;
  reg [23:0] base_ff, nxt_base;
  reg [23:0] target_ff, nxt_target;
  reg [3:0] run_op_ff, nxt_run_op;
  reg store_ph_ff;
  reg [15:0] rdata_nxt;

  wire [23:0] store_addr = {page_ff, i_effective_pointer};
  wire [IDX_W-1:0] store_idx = store_addr[IDX_W:1];
  wire [1:0] store_be = i_byte_mode ? (i_effective_pointer[0] ? 2'h2 : 2'h1) : 2'h3;
  wire [15:0] store_wd = (i_byte_mode && i_effective_pointer[0]) ? {i_store_data[7:0], 8'h00} : i_store_data;
  wire [IDX_W-1:0] rd_idx = cnt_ff[IDX_W-1:0];
  wire [23:0] latch_q;
  wire busy = (state_ff != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // decode shared by the sequencer and the array drive
  wire start_word = (opsel_ff == `FSPC_OP_WORD);
  wire run_row = (run_op_ff == `FSPC_OP_ROW);
  wire row_left = (cnt_ff < ROW_COUNT);
  wire timer_out = (timer_ff <= 32'h1);
  wire launch_erase = (state_ff == ST_IDLE) && (nxt_state == ST_ERASE);
  wire prog_issue = (state_ff == ST_PROG) && (run_row ? row_left : (timer_ff == PROG_CYCLES));

  // each store takes two cycles: the latch is written in the first, the core released in the second
  always @(posedge i_clk) begin
    if (i_rst) store_ph_ff <= 1'b0;
    else store_ph_ff <= i_latch_store_op & ~store_ph_ff & ~busy;
  end
  assign o_store_done = store_ph_ff;
  assign o_core_stall = busy | start_ff;

  fspc_latch #(.ROW_WORDS(ROW_WORDS), .IDX_W(IDX_W)) u_latch (
    .i_clk(i_clk),
    .i_wr(i_latch_store_op & ~store_ph_ff & ~busy),
    .i_wr_idx(store_idx),
    .i_hi(i_high_latch_store),
    .i_be(store_be),
    .i_wdata(store_wd),
    .i_rd_idx(rd_idx),
    .o_rdata(latch_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // operation decode: code and erase-select must agree
  reg op_valid;
  reg op_is_erase;
  always @* begin
    op_valid = 1'b0;
    op_is_erase = 1'b0;
    case (opsel_ff)
      `FSPC_OP_WORD: op_valid = ~erase_ff;
      `FSPC_OP_ROW: op_valid = ~erase_ff;
      `FSPC_OP_BLOCK: begin
        op_valid = erase_ff;
        op_is_erase = 1'b1;
      end
      `FSPC_OP_BULK: begin
        op_valid = erase_ff & i_serial_programming;
        op_is_erase = 1'b1;
      end
      default: op_valid = 1'b0;
    endcase
  end

  wire wr_ctrl = i_wr && (i_addr == `FSPC_ADDR_CTRL) && !busy;
  wire wr_key = i_wr && (i_addr == `FSPC_ADDR_KEY);
  wire start_req = wr_ctrl && i_wdata[`FSPC_BIT_START] && !start_ff;
  wire wr_allow = wr_ctrl ? i_wdata[`FSPC_BIT_ALLOW] : allow_ff;
  wire start_ok = start_req && (key_ff == KEY_OK) && wr_allow;

  ////////////////////////////////////////////////////////////////////////////////
  always @* begin
    nxt_start = start_ff;
    nxt_allow = allow_ff;
    nxt_fault = fault_ff;
    nxt_erase = erase_ff;
    nxt_opsel = opsel_ff;
    nxt_page = page_ff;
    nxt_key = key_ff;
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    nxt_cnt = cnt_ff;
    nxt_base = base_ff;
    nxt_target = target_ff;
    nxt_run_op = run_op_ff;
    // any bus write other than the second key byte breaks the unlock
    if (i_wr) nxt_key = KEY_NONE;
    if (wr_key && i_wdata[7:0] == `FSPC_KEY_FIRST) nxt_key = KEY_ONE;
    if (wr_key && i_wdata[7:0] == `FSPC_KEY_SECOND && key_ff == KEY_ONE) nxt_key = KEY_OK;
    // page pointer supplies the upper byte of every store address
    if (i_wr && i_addr == `FSPC_ADDR_PAGE) nxt_page = i_wdata[7:0];
    if (i_latch_store_op && !store_ph_ff) nxt_target = store_addr;
    if (wr_ctrl) begin
      nxt_allow = i_wdata[`FSPC_BIT_ALLOW];
      nxt_erase = i_wdata[`FSPC_BIT_ERASE];
      nxt_opsel = i_wdata[3:0];
    end
    if (start_req) begin
      if (start_ok) nxt_start = 1'b1;
      else nxt_fault = 1'b1;
    end
    case (state_ff)
      ST_IDLE: begin
        if (start_ff) begin
          nxt_run_op = opsel_ff;
          nxt_cnt = {(IDX_W+4){1'b0}};
          // a no-operation start still passes through done, which clears start and fault
          if (!op_valid) begin
            nxt_state = ST_DONE;
          end else if (op_is_erase) begin
            nxt_state = ST_ERASE;
            nxt_timer = ERASE_CYCLES;
            nxt_base = fspc_align(target_ff, BLK_SPAN);
          end else begin
            nxt_state = ST_PROG;
            nxt_timer = PROG_CYCLES;
            nxt_base = start_word ? target_ff : fspc_align(target_ff, ROW_SPAN);
            if (start_word) nxt_cnt = {{4{1'b0}}, target_ff[IDX_W:1]};
          end
        end
      end
      ST_PROG: begin
        // a short program time never cuts a row: all words are issued before the end
        if (!timer_out) nxt_timer = timer_ff - 32'h1;
        else if (!run_row || !row_left) nxt_state = ST_DONE;
        if (row_left && run_row) nxt_cnt = cnt_ff + 1'b1;
      end
      ST_ERASE: begin
        // erase is purely timed; the array side only sees the launch pulse
        if (!timer_out) nxt_timer = timer_ff - 32'h1;
        else nxt_state = ST_DONE;
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
        nxt_start = 1'b0;
        nxt_fault = 1'b0;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // array drive: row program emits one word per cycle from the latches (read one cycle late)
  reg prog_wr_d;
  reg [23:0] prog_addr_d;
  always @(posedge i_clk) begin
    if (i_rst) begin
      prog_wr_d <= 1'b0;
      prog_addr_d <= 24'h000000;
      o_arr_wr <= 1'b0;
      o_arr_erase <= 1'b0;
      o_arr_addr <= 24'h000000;
      o_arr_data <= 24'h000000;
      o_arr_count <= {(IDX_W+4){1'b0}};
    end else begin
      prog_wr_d <= prog_issue;
      prog_addr_d <= run_row ? base_ff + {13'h0000, cnt_ff, 1'b0} : base_ff;
      o_arr_wr <= prog_wr_d;
      if (prog_wr_d) o_arr_addr <= prog_addr_d;
      else if (launch_erase) o_arr_addr <= nxt_base;
      o_arr_data <= latch_q;
      o_arr_erase <= launch_erase;
      // bulk erase reports zero words, meaning the whole array
      if (opsel_ff == `FSPC_OP_BULK) o_arr_count <= {(IDX_W+4){1'b0}};
      else o_arr_count <= BLK_COUNT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control bits survive ordinary resets and clear only on power-on
  always @(posedge i_clk) begin
    if (i_por) begin
      start_ff <= 1'b0;
      allow_ff <= 1'b0;
      fault_ff <= 1'b0;
      erase_ff <= 1'b0;
      opsel_ff <= 4'h0;
    end else begin
      start_ff <= nxt_start;
      allow_ff <= nxt_allow;
      fault_ff <= nxt_fault;
      erase_ff <= nxt_erase;
      opsel_ff <= nxt_opsel;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst | i_por) begin
      page_ff <= 8'h00;
      key_ff <= KEY_NONE;
      state_ff <= ST_IDLE;
      timer_ff <= 32'h0;
      cnt_ff <= {(IDX_W+4){1'b0}};
      base_ff <= 24'h000000;
      target_ff <= 24'h000000;
      run_op_ff <= 4'h0;
      o_rdata <= 16'h0000;
    end else begin
      page_ff <= nxt_page;
      key_ff <= nxt_key;
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      cnt_ff <= nxt_cnt;
      base_ff <= nxt_base;
      target_ff <= nxt_target;
      run_op_ff <= nxt_run_op;
      o_rdata <= rdata_nxt;
    end
  end

  // control word as software reads it
  wire [15:0] ctrl_word = {start_ff, allow_ff, fault_ff, 6'h00,
    erase_ff, 2'h0, opsel_ff};

  // key register is write-only and reads zero; unimplemented bits read zero
  always @* begin
    rdata_nxt = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        `FSPC_ADDR_CTRL: rdata_nxt = ctrl_word;
        `FSPC_ADDR_PAGE: rdata_nxt = {8'h00, page_ff};
        `FSPC_ADDR_STAT: rdata_nxt = {14'h0000, state_ff};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end
endmodule // fspc_ctrl
`default_nettype wire

// *** testbench/fspc_props.sv ***
// property checker on the flash self-programming controller ports
`timescale 1ns/1ps
`default_nettype none
module fspc_props #(
  parameter IDX_W = 6
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_serial_programming,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_latch_store_op,
  input wire logic o_store_done,
  input wire logic o_core_stall,
  input wire logic o_arr_wr,
  input wire logic o_arr_erase,
  input wire logic [IDX_W+3:0] o_arr_count
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst || i_por);
  AST_RSVD_ZERO: assert property (i_rd && i_addr == 4'h0 |=> o_rdata[12:7] == 6'h00 && o_rdata[5:4] == 2'h0)
    else $error("reserved control bits set");
  AST_KEY_HIDDEN: assert property (i_rd && i_addr == 4'h1 |=> o_rdata == 16'h0000)
    else $error("key register readable");
  AST_STALL_ENDS: assert property ($rose(o_core_stall) |-> ##[1:200] !o_core_stall)
    else $error("stall never released");
  AST_STORE_TWO: assert property (i_latch_store_op && !o_store_done && !o_core_stall |=> o_store_done ##1 !o_store_done)
    else $error("store not done in two cycles");
  AST_WR_BUSY: assert property (o_arr_wr |-> o_core_stall)
    else $error("array write outside a sequence");
  AST_NO_ALLOW: assert property (i_wr && i_addr == 4'h0 && i_wdata[15] && !i_wdata[14] && !o_core_stall
    |=> !o_core_stall [*3])
    else $error("start ran without modify allow");
  AST_BLOCK_SIZE: assert property (o_arr_erase |-> o_arr_count == 512 || (o_arr_count == 0 && i_serial_programming))
    else $error("erase size wrong");
  AST_BULK_MODE: assert property (o_arr_erase && o_arr_count == 0 |-> i_serial_programming)
    else $error("bulk erase outside serial mode");
  cover property (o_arr_erase);
  cover property (o_arr_wr);
  cover property (o_store_done);
endmodule // fspc_props
`default_nettype wire

// *** testbench/fspc_core_model.sv ***
// core-side model issuing latch stores
`timescale 1ns/1ps
`default_nettype none
module fspc_core_model (
  input wire logic i_clk,
  input wire logic i_store_done,
  output logic o_op,
  output logic o_high,
  output logic [15:0] o_ptr,
  output logic [15:0] o_data
);
  int waits;
  initial begin
    o_op = 1'b0;
    o_high = 1'b0;
    o_ptr = 16'h0000;
    o_data = 16'h0000;
  end
  task automatic store(input logic hi, input logic [15:0] ptr, input logic [15:0] d);
    @(posedge i_clk);
    o_op <= 1'b1;
    o_high <= hi;
    o_ptr <= ptr;
    o_data <= d;
    waits = 0;
    do begin
      @(posedge i_clk);
      #1;
      waits++;
    end while (!i_store_done && waits < 8);
    @(posedge i_clk);
    o_op <= 1'b0;
    // released lines must not keep showing the old store
    o_ptr <= ~ptr;
    o_data <= ~d;
  endtask
endmodule // fspc_core_model
`default_nettype wire

// *** testbench/fspc_ctrl_tb.sv ***
// self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_por = 1'b1;
  logic sp = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic bm = 1'b0;
  logic [15:0] rdata, ptr, sd;
  logic op, hi, done, stall, aw, ae;
  logic [23:0] aa, ad, ea;
  logic [9:0] ac, ec;
  logic [23:0] wa [0:127];
  logic [23:0] wd [0:127];
  logic [15:0] ops [8] = '{16'hc003, 16'hc042, 16'hc002, 16'hc041, 16'hc04f, 16'hc04f, 16'hc005, 16'hc00f};
  int sps [8] = '{0, 0, 0, 0, 0, 1, 0, 0};
  int nws [8] = '{1, 0, 0, 0, 0, 0, 0, 0};
  int nes [8] = '{0, 1, 0, 0, 0, 1, 0, 0};
  int nw, ne, n_errors = 0, n_checks = 0;
  always #5 i_clk = ~i_clk;
  fspc_ctrl #(.PROG_CYCLES(10), .ERASE_CYCLES(20)) i_fspc_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_por(i_por),
    .i_serial_programming(sp), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .i_latch_store_op(op), .i_high_latch_store(hi), .i_byte_mode(bm), .i_effective_pointer(ptr),
    .i_store_data(sd), .o_store_done(done), .o_core_stall(stall), .o_arr_wr(aw), .o_arr_erase(ae),
    .o_arr_addr(aa), .o_arr_data(ad), .o_arr_count(ac));
  fspc_core_model i_core (.i_clk(i_clk), .i_store_done(done), .o_op(op), .o_high(hi), .o_ptr(ptr), .o_data(sd));
  always @(posedge i_clk) begin
    if (aw) begin
      wa[nw] = aa;
      wd[nw] = ad;
      nw++;
    end
    if (ae) begin
      ea = aa;
      ec = ac;
      ne++;
    end
  end
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    rd_s <= 1'b0;
    #1;
    chk(nm, {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic run(input logic [15:0] c, input logic s);
    sp <= s;
    wr(4'h1, 16'h0055);
    wr(4'h1, 16'h00aa);
    nw = 0;
    ne = 0;
    wr(4'h0, c);
    repeat (3) @(posedge i_clk);
    for (int t = 0; t < 3000 && stall !== 1'b0; t++) @(posedge i_clk);
    chk("stall released", 24'd0, {23'd0, stall});
    rd("control after run", 4'h0, c & 16'h404f & 16'h7fff);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    i_por <= 1'b0;
    wr(4'h0, 16'hbfff);
    rd("control fields", 4'h0, 16'h204f);
    rd("key readback", 4'h1, 16'h0000);
    rd("unmapped", 4'h9, 16'h0000);
    wr(4'h1, 16'h0055);
    wr(4'h1, 16'h00aa);
    wr(4'h2, 16'h0001);
    wr(4'h0, 16'hc001);
    rd("start refused", 4'h0, 16'h6001);
    $display("register test done");
    i_core.store(1'b0, 16'h008a, 16'hdead);
    // every word of the row is defined so no stale latch reaches the array
    for (int i = 63; i >= 0; i--) begin
      i_core.store(1'b0, 16'h0080 + 16'(2 * i), 16'h1000 + 16'(i));
      i_core.store(1'b1, 16'h0080 + 16'(2 * i), 16'h0040 + 16'(i));
      chk("store cycles", 24'd1, 24'(i_core.waits));
    end
    run(16'hc001, 1'b0);
    chk("row writes", 24'd64, 24'(nw));
    for (int i = 0; i < 64; i++) begin
      chk("row address", 24'h010080 + 24'(2 * i), wa[i]);
      chk("row data", {8'h40 + 8'(i), 16'h1000 + 16'(i)}, wd[i]);
    end
    $display("row test done");
    wr(4'h2, 16'h0002);
    i_core.store(1'b0, 16'h0468, 16'hff34);
    bm <= 1'b1;
    i_core.store(1'b0, 16'h0469, 16'hcd12);
    bm <= 1'b0;
    i_core.store(1'b1, 16'h0468, 16'h005a);
    for (int k = 0; k < 8; k++) begin
      run(ops[k], sps[k][0]);
      chk("array writes", 24'(nws[k]), 24'(nw));
      chk("erases", 24'(nes[k]), 24'(ne));
      if (ops[k] == 16'hc003) begin
        chk("word data", 24'h5a1234, wd[0]);
        chk("word address", 24'h020468, wa[0]);
      end
      if (nes[k] != 0)
        chk("erase size", (ops[k][3:0] == 4'hf) ? 24'd0 : 24'd512, {14'd0, ec});
      if (ops[k] == 16'hc042)
        chk("block base", 24'h020400, ea);
    end
    $display("operation test done");
    wr(4'h0, 16'h4041);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd("after plain reset", 4'h0, 16'h4041);
    i_por <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_por <= 1'b0;
    rd("after power-on reset", 4'h0, 16'h0000);
    rd("status idle", 4'h3, 16'h0000);
    $display("reset test done");
    conclude();
  end
  initial begin
    #500000;
    n_errors++;
    conclude();
  end
endmodule // fspc_ctrl_tb
bind fspc_ctrl fspc_props #(.IDX_W(IDX_W)) i_fspc_props (.i_clk(i_clk), .i_rst(i_rst), .i_por(i_por),
  .i_serial_programming(i_serial_programming), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_latch_store_op(i_latch_store_op), .o_store_done(o_store_done),
  .o_core_stall(o_core_stall), .o_arr_wr(o_arr_wr), .o_arr_erase(o_arr_erase), .o_arr_count(o_arr_count));
`default_nettype wire
